// ---- isbsc_cpu_model.sv ----
// cpu core model: sfr bus accesses, idle level and wake-up interrupt
// assumes the bench calls its tasks just after a falling edge of clk
`timescale 1ns/1ps
module isbsc_cpu_model (
   input  wire logic       clk,
   output logic      [7:0] sfr_addr,
   output logic      [7:0] sfr_wdata,
   output logic            sfr_wr,
   output logic            sfr_rd,
   input  wire logic [7:0] sfr_rdata,
   output logic            cpu_idle,
   output logic            cpu_wake_irq
);
   // quiet bus at time zero
   initial begin
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      cpu_idle = 1'b0;
      cpu_wake_irq = 1'b0;
   end
   // one write; bits 3 and 2 of a control register write always go out as zero
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk); // free cycle first: a strobe never drops and rises in one step
      sfr_addr = a;
      sfr_wdata = (a == isbsc_pkg::ADDR_PROG_CTRL) ? (d & 8'hf3) : d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
      sfr_wdata = ~sfr_wdata; // released data must not look valid
   endtask
   // one read; data is registered, so it is taken one cycle on
   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk); // free cycle first, as for writes
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk);
      sfr_rd = 1'b0;
      d = sfr_rdata;
   endtask
   // the two keys back to back open the control register
   task automatic unlock();
      sfr_write(isbsc_pkg::ADDR_UNLOCK, isbsc_pkg::UNLOCK_KEY1);
      sfr_write(isbsc_pkg::ADDR_UNLOCK, isbsc_pkg::UNLOCK_KEY2);
   endtask
   // one-cycle wake-up interrupt
   task automatic wake();
      @(negedge clk); // free cycle first, so back to back pulses stay apart
      cpu_wake_irq = 1'b1;
      @(negedge clk);
      cpu_wake_irq = 1'b0;
   endtask
   task automatic set_idle(input logic v);
      cpu_idle = v;
   endtask
endmodule

// ---- isbsc_ctrl.sv ----
// isp programming control, loader-boot selection and code protection
// assumes sfr strobes, idle/wake and programmer strobes are synchronous to clk
//
// Notes on behaviour
// - control write with bits 7,1,0 reboots chip
// - bit 7 reads 1 in loader boot
// - bit 4 enables auxiliary ram
// - location 0: loader in app, dest loader
// - location 1: loader in 4k, dest app
// - isp mode entered on wake from idle
// - flash operations run only while idle
// - program enable low refuses erase/program
// - default boot from application bank
// - pins P2.7/P2.6 low or P4.3 low
// - special registers blocked in programming mode
// - programmed security bits stay low till erase
// - security register at loader top address
// - identity registers fixed, never writable
// - lock bit low blocks code and specials
// - inhibit low: external movc reads external
// - internal movc reads everywhere
// - inhibit high: movc unrestricted
// - encryption scrambles port 0 data
// - encryption cleared only by erase-all
// - control writable after 87h then 59h
// - erase 0010, program 0001, read 0000
`timescale 1ns/1ps
module isbsc_ctrl #(
   parameter logic [7:0] COMPANY_ID = 8'h5a,        // arbitrary value
   parameter logic [7:0] DEVICE_ID  = 8'ha5,        // arbitrary value
   parameter logic [7:0] ENC_KEY    = 8'h3c,
   parameter logic [7:0] SEC_INIT   = 8'hff
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic [7:0]  sfr_wdata,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   output logic      [7:0]  sfr_rdata,
   input  wire logic        boot_p2_7,
   input  wire logic        boot_p2_6,
   input  wire logic        boot_p4_3,
   input  wire logic        cpu_idle,
   input  wire logic        cpu_wake_irq,
   output logic             soft_reboot,
   output logic             loader_boot_mode,
   output logic             aux_ram_enable,
   output logic             loader_location_select,
   output logic             program_enable,
   output logic             destination_bank_select,
   output logic             isp_mode,
   output logic             exec_loader_bank,
   input  wire logic        flash_req,
   input  wire logic [3:0]  flash_cmd,
   output logic             flash_go,
   output logic             flash_refused,
   output logic      [3:0]  flash_op,
   input  wire logic        prog_rd,
   input  wire logic        prog_wr,
   input  wire logic        prog_erase_all,
   input  wire logic        prog_loader_bank,
   input  wire logic [15:0] prog_addr,
   input  wire logic [7:0]  prog_wdata,
   output logic      [7:0]  prog_rdata,
   output logic             prog_refused,
   output logic             prog_code_go,
   output logic      [7:0]  code_protection_settings,
   input  wire logic        movc_req,
   input  wire logic        movc_from_internal,
   input  wire logic        movc_target_internal,
   output logic             movc_use_internal,
   input  wire logic [7:0]  p0_data_in,
   output logic      [7:0]  p0_data_out
);

   // decode shared by the flash path and its checks
   function automatic logic is_write_cmd(input logic [3:0] cmd);
      is_write_cmd = (cmd == isbsc_pkg::FLASH_ERASE) || (cmd == isbsc_pkg::FLASH_PROGRAM);
   endfunction

   isbsc_pkg::isbsc_unlock_t unlock_r, unlock_nxt;
   logic       reboot_nxt, boot_nxt, aux_nxt, loc_nxt, pen_nxt, isp_nxt, exec_nxt;
   logic       pend_r, pend_nxt, go_nxt, ref_nxt, pref_nxt, pgo_nxt, movc_nxt;
   logic [3:0] op_nxt;
   logic [7:0] rdata_nxt, sec_nxt, prd_nxt, p0_nxt;
   logic       wr_ctrl, wr_unlock, do_reboot;
   assign wr_ctrl   = sfr_wr && (sfr_addr == isbsc_pkg::ADDR_PROG_CTRL);
   assign wr_unlock = sfr_wr && (sfr_addr == isbsc_pkg::ADDR_UNLOCK);
   assign do_reboot = wr_ctrl && (unlock_r == isbsc_pkg::ISBSC_OPEN)
                      && ((sfr_wdata & isbsc_pkg::REBOOT_MASK) == isbsc_pkg::REBOOT_MASK);
   ////////////////////////////////////////////////////////////////////////////
   // unlock sequence: any other value closes, 87h may restart it
   always_comb begin
      unlock_nxt = unlock_r;
      if (do_reboot) begin
         unlock_nxt = isbsc_pkg::ISBSC_CLOSED;
      end else if (wr_unlock) begin
         unique case (1'b1)
            sfr_wdata == isbsc_pkg::UNLOCK_KEY1: unlock_nxt = isbsc_pkg::ISBSC_HALF;
            sfr_wdata == isbsc_pkg::UNLOCK_KEY2 && unlock_r == isbsc_pkg::ISBSC_HALF:
               unlock_nxt = isbsc_pkg::ISBSC_OPEN;
            default:                               unlock_nxt = isbsc_pkg::ISBSC_CLOSED;
         endcase
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         unlock_r <= isbsc_pkg::ISBSC_CLOSED;
      end else begin
         unlock_r <= unlock_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // control bits, boot strap sampling, isp mode; reboot acts like power-on
   always_comb begin
      reboot_nxt = do_reboot;
      pend_nxt   = 1'b0;
      boot_nxt   = loader_boot_mode;
      aux_nxt    = aux_ram_enable;
      loc_nxt    = loader_location_select;
      pen_nxt    = program_enable;
      isp_nxt    = isp_mode;
      if (pend_r) begin
         // straps caught one edge after reset release, never inside the reset
         boot_nxt = (!boot_p2_7 && !boot_p2_6) || !boot_p4_3;
      end
      if (wr_ctrl && unlock_r == isbsc_pkg::ISBSC_OPEN && !do_reboot) begin
         aux_nxt = sfr_wdata[isbsc_pkg::BIT_AUX_RAM];
         loc_nxt = sfr_wdata[isbsc_pkg::BIT_LOC_SEL];
         pen_nxt = sfr_wdata[isbsc_pkg::BIT_PROG_EN];
      end
      if (cpu_wake_irq) begin
         isp_nxt = program_enable;
      end
      if (do_reboot) begin
         pend_nxt = 1'b1;
         aux_nxt  = isbsc_pkg::CTRL_BIT_RESET;
         loc_nxt  = isbsc_pkg::CTRL_BIT_RESET;
         pen_nxt  = isbsc_pkg::CTRL_BIT_RESET;
         isp_nxt  = 1'b0;
      end
      // outside isp the strap picks the bank, inside it the loader location does
      exec_nxt = isp_nxt ? loc_nxt : boot_nxt;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         soft_reboot             <= 1'b0;
         pend_r                  <= 1'b1;
         loader_boot_mode        <= 1'b0;
         aux_ram_enable          <= isbsc_pkg::CTRL_BIT_RESET;
         loader_location_select  <= isbsc_pkg::CTRL_BIT_RESET;
         program_enable          <= isbsc_pkg::CTRL_BIT_RESET;
         destination_bank_select <= 1'b1;
         isp_mode                <= 1'b0;
         exec_loader_bank        <= 1'b0;
      end else begin
         soft_reboot             <= reboot_nxt;
         pend_r                  <= pend_nxt;
         loader_boot_mode        <= boot_nxt;
         aux_ram_enable          <= aux_nxt;
         loader_location_select  <= loc_nxt;
         program_enable          <= pen_nxt;
         destination_bank_select <= !loc_nxt;
         isp_mode                <= isp_nxt;
         exec_loader_bank        <= exec_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // sfr read-back; reserved and must-be-zero bits read 0
   always_comb begin
      rdata_nxt = 8'h00;
      if (sfr_rd && sfr_addr == isbsc_pkg::ADDR_PROG_CTRL) begin
         rdata_nxt[isbsc_pkg::BIT_REBOOT]  = loader_boot_mode;
         rdata_nxt[isbsc_pkg::BIT_AUX_RAM] = aux_ram_enable;
         rdata_nxt[isbsc_pkg::BIT_LOC_SEL] = loader_location_select;
         rdata_nxt[isbsc_pkg::BIT_PROG_EN] = program_enable;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sfr_rdata <= 8'h00;
      end else begin
         sfr_rdata <= rdata_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // cpu flash requests: granted only in isp mode while the core idles
   always_comb begin
      go_nxt  = 1'b0;
      ref_nxt = 1'b0;
      op_nxt  = flash_op;
      if (flash_req) begin
         if (isp_mode && cpu_idle
             && (flash_cmd == isbsc_pkg::FLASH_READ || is_write_cmd(flash_cmd))
             && (!is_write_cmd(flash_cmd) || program_enable)) begin
            go_nxt = 1'b1;
            op_nxt = flash_cmd;
         end else begin
            ref_nxt = 1'b1;
         end
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flash_go      <= 1'b0;
         flash_refused <= 1'b0;
         flash_op      <= isbsc_pkg::FLASH_READ;
      end else begin
         flash_go      <= go_nxt;
         flash_refused <= ref_nxt;
         flash_op      <= op_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // programmer port: security byte can only lose ones, erase-all restores it
   logic special, blocked, locked;
   assign locked  = !code_protection_settings[isbsc_pkg::SEC_LOCK];
   assign special = prog_loader_bank && (prog_addr == isbsc_pkg::ADDR_SECURITY
                    || prog_addr == isbsc_pkg::ADDR_COMPANY
                    || prog_addr == isbsc_pkg::ADDR_DEVICE);
   assign blocked = locked || (special && isp_mode);

   always_comb begin
      sec_nxt  = code_protection_settings;
      prd_nxt  = prog_rdata;
      pref_nxt = 1'b0;
      pgo_nxt  = 1'b0;
      if (prog_erase_all) begin
         sec_nxt = isbsc_pkg::SEC_ERASED;
         pgo_nxt = 1'b1;
      end else if (prog_rd || prog_wr) begin
         if (blocked) begin
            pref_nxt = 1'b1;
         end else if (!special) begin
            pgo_nxt = 1'b1;
         end else if (prog_wr) begin
            if (prog_addr == isbsc_pkg::ADDR_SECURITY) begin
               sec_nxt = code_protection_settings & prog_wdata;
            end else begin
               pref_nxt = 1'b1;
            end
         end else begin
            unique case (1'b1)
               prog_addr == isbsc_pkg::ADDR_SECURITY: prd_nxt = code_protection_settings;
               prog_addr == isbsc_pkg::ADDR_COMPANY:  prd_nxt = COMPANY_ID;
               default:                               prd_nxt = DEVICE_ID;
            endcase
         end
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         code_protection_settings <= SEC_INIT;
         prog_rdata               <= 8'h00;
         prog_refused             <= 1'b0;
         prog_code_go             <= 1'b0;
      end else begin
         code_protection_settings <= sec_nxt;
         prog_rdata               <= prd_nxt;
         prog_refused             <= pref_nxt;
         prog_code_go             <= pgo_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // movc gate and port 0 scrambling; the xor key is a weak cipher by design
   always_comb begin
      movc_nxt = movc_req && movc_target_internal
                 && (movc_from_internal
                     || code_protection_settings[isbsc_pkg::SEC_MOVC_INH]);
      p0_nxt   = code_protection_settings[isbsc_pkg::SEC_ENCRYPT] ? p0_data_in
                 : (p0_data_in ^ ENC_KEY);
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         movc_use_internal <= 1'b0;
         p0_data_out       <= 8'h00;
      end else begin
         movc_use_internal <= movc_nxt;
         p0_data_out       <= p0_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_ctrl_locked: assert property (
      (wr_ctrl && unlock_r != isbsc_pkg::ISBSC_OPEN) |=> $stable(program_enable))
      else $error("control register changed while write access closed");
   chk_reboot_seq: assert property (
      do_reboot |=> soft_reboot && !program_enable ##1 !isp_mode)
      else $error("soft reboot did not restore initial state");
   chk_boot_bit: assert property (
      (sfr_rd && sfr_addr == isbsc_pkg::ADDR_PROG_CTRL)
      |=> sfr_rdata[7] == $past(loader_boot_mode))
      else $error("bit 7 does not show loader boot mode");
   // judged against the written bit, not the stored copy, so a wrong invert shows
   chk_dest_bank: assert property (
      (wr_ctrl && unlock_r == isbsc_pkg::ISBSC_OPEN && !do_reboot)
      |=> destination_bank_select == !$past(sfr_wdata[isbsc_pkg::BIT_LOC_SEL]))
      else $error("destination bank disagrees with written loader location");
   chk_isp_entry: assert property (
      (cpu_wake_irq && program_enable && !do_reboot) |=> isp_mode)
      else $error("isp mode not entered after wake");
   chk_op_idle: assert property (
      flash_go |-> $past(cpu_idle) && $past(isp_mode))
      else $error("flash operation outside idle isp mode");
   chk_pen_refuse: assert property (
      (flash_req && is_write_cmd(flash_cmd) && !program_enable) |=> flash_refused && !flash_go)
      else $error("write operation not refused with programming disabled");
   chk_sec_sticky: assert property (
      !$past(prog_erase_all)
      |-> (code_protection_settings & ~$past(code_protection_settings)) == 8'h00)
      else $error("security bit returned to one without erase");
   chk_lock_block: assert property (
      (locked && prog_rd && !prog_erase_all) |=> prog_refused && !prog_code_go)
      else $error("locked device allowed an access");
   chk_movc_ext: assert property (
      (!code_protection_settings[isbsc_pkg::SEC_MOVC_INH] && !movc_from_internal)
      |=> !movc_use_internal)
      else $error("external movc reached internal code");
   chk_p0_encrypt: assert property (
      !code_protection_settings[isbsc_pkg::SEC_ENCRYPT]
      |=> p0_data_out == ($past(p0_data_in) ^ ENC_KEY))
      else $error("port 0 data not encrypted");
   cov_unlock_open: cover property (wr_unlock ##1 unlock_r == isbsc_pkg::ISBSC_OPEN);
   cov_isp_op:      cover property (isp_mode ##[1:20] flash_go);
   cov_reboot:      cover property (do_reboot ##2 pend_r == 1'b0);
   cov_loader_boot: cover property (loader_boot_mode && exec_loader_bank);

endmodule

// ---- isbsc_pkg.sv ----
// constants shared by the isp / boot / code-protection controller
// assumes an 8-bit sfr bus from the cpu core and a byte-wide programmer port
package isbsc_pkg;
   // sfr map
   localparam logic [7:0]  ADDR_PROG_CTRL = 8'hbf;   // isp_program_control
   localparam logic [7:0]  ADDR_UNLOCK    = 8'hf6;   // isp_write_unlock
   localparam logic [7:0]  UNLOCK_KEY1    = 8'h87;
   localparam logic [7:0]  UNLOCK_KEY2    = 8'h59;
   // isp_program_control fields
   localparam int          BIT_REBOOT     = 7;       // write: soft_reboot, read: indicator
   localparam int          BIT_AUX_RAM    = 4;
   localparam int          BIT_LOC_SEL    = 1;
   localparam int          BIT_PROG_EN    = 0;
   localparam logic [7:0]  REBOOT_MASK    = 8'h83;
   localparam logic        CTRL_BIT_RESET = 1'b0;
   // programmer-side special setting registers, loader bank space
   localparam logic [15:0] ADDR_SECURITY  = 16'hffff;
   localparam logic [15:0] ADDR_COMPANY   = 16'hfffe;
   localparam logic [15:0] ADDR_DEVICE    = 16'hfffd;
   // code_protection_settings fields, 0 means programmed (active)
   localparam int          SEC_LOCK       = 0;
   localparam int          SEC_MOVC_INH   = 1;
   localparam int          SEC_ENCRYPT    = 2;
   localparam logic [7:0]  SEC_ERASED     = 8'hff;
   // code-memory control field
   localparam logic [3:0]  FLASH_ERASE    = 4'h2;
   localparam logic [3:0]  FLASH_PROGRAM  = 4'h1;
   localparam logic [3:0]  FLASH_READ     = 4'h0;
   // write-access unlock sequence
   typedef enum logic [2:0] {
      ISBSC_CLOSED = 3'b001,
      ISBSC_HALF   = 3'b010,
      ISBSC_OPEN   = 3'b100
   } isbsc_unlock_t;
endpackage

// ---- isbsc_tb.sv ----
// self-checking bench for the isp / boot / code-protection controller
// assumes isbsc_ctrl with default ids 5a/a5 and encryption key 3c
`timescale 1ns/1ps
module testbench;
   logic        clk, rst_b, sfr_wr, sfr_rd, boot_p2_7, boot_p2_6, boot_p4_3;
   logic        cpu_idle, cpu_wake_irq, soft_reboot, loader_boot_mode, aux_ram_enable;
   logic        loader_location_select, program_enable, destination_bank_select, isp_mode;
   logic        exec_loader_bank, flash_req, flash_go, flash_refused, prog_rd, prog_wr;
   logic        prog_erase_all, prog_loader_bank, prog_refused, prog_code_go, movc_req;
   logic        movc_from_internal, movc_target_internal, movc_use_internal;
   logic [3:0]  flash_cmd, flash_op;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, prog_wdata, prog_rdata, sec, p0_in, p0_out, rd;
   logic [15:0] prog_addr;
   int          fails, checks, cycles;
   isbsc_ctrl DUT (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .boot_p2_7(boot_p2_7),
      .boot_p2_6(boot_p2_6), .boot_p4_3(boot_p4_3), .cpu_idle(cpu_idle),
      .cpu_wake_irq(cpu_wake_irq), .soft_reboot(soft_reboot), .loader_boot_mode(loader_boot_mode),
      .aux_ram_enable(aux_ram_enable), .loader_location_select(loader_location_select),
      .program_enable(program_enable), .destination_bank_select(destination_bank_select),
      .isp_mode(isp_mode), .exec_loader_bank(exec_loader_bank), .flash_req(flash_req),
      .flash_cmd(flash_cmd), .flash_go(flash_go), .flash_refused(flash_refused),
      .flash_op(flash_op), .prog_rd(prog_rd), .prog_wr(prog_wr), .prog_erase_all(prog_erase_all),
      .prog_loader_bank(prog_loader_bank), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
      .prog_rdata(prog_rdata), .prog_refused(prog_refused), .prog_code_go(prog_code_go),
      .code_protection_settings(sec), .movc_req(movc_req), .movc_from_internal(movc_from_internal),
      .movc_target_internal(movc_target_internal), .movc_use_internal(movc_use_internal),
      .p0_data_in(p0_in), .p0_data_out(p0_out));
   isbsc_cpu_model cpu (.clk(clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .cpu_idle(cpu_idle), .cpu_wake_irq(cpu_wake_irq));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard, far above the under two hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("timeout after %0d cycles", cycles);
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // straps are held through reset and sampled at the first edge after it
   task automatic do_reset(input logic p27, input logic p26, input logic p43);
      @(negedge clk);
      rst_b = 1'b0;
      boot_p2_7 = p27;
      boot_p2_6 = p26;
      boot_p4_3 = p43;
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      repeat (2) @(negedge clk);
   endtask
   task automatic flash(input logic [3:0] c, input logic go);
      @(negedge clk); // free cycle first: the request never drops and rises in one step
      flash_req = 1'b1;
      flash_cmd = c;
      @(negedge clk);
      flash_req = 1'b0;
      check("flash_go", 16'(go), 16'(flash_go));
      check("flash_refused", 16'(!go), 16'(flash_refused));
      if (go) check("flash_op", 16'(c), 16'(flash_op));
   endtask
   task automatic prog(input logic r, w, e, b, input logic [15:0] a, input logic [7:0] d);
      @(negedge clk); // free cycle first, as for flash requests
      {prog_rd, prog_wr, prog_erase_all, prog_loader_bank} = {r, w, e, b};
      prog_addr = a;
      prog_wdata = d;
      @(negedge clk);
      {prog_rd, prog_wr, prog_erase_all} = 3'h0;
      prog_wdata = ~d;
   endtask
   task automatic movc(input logic from_int, input logic exp);
      @(negedge clk); // free cycle first, as for flash requests
      {movc_req, movc_from_internal, movc_target_internal} = {1'b1, from_int, 1'b1};
      @(negedge clk);
      movc_req = 1'b0;
      check("movc_use_internal", 16'(exp), 16'(movc_use_internal));
   endtask
   task automatic port0(input logic [7:0] v, input logic [7:0] exp);
      p0_in = v;
      @(negedge clk);
      check("p0_data_out", 16'(exp), 16'(p0_out));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_ctrl();
      cpu.sfr_read(isbsc_pkg::ADDR_PROG_CTRL, rd);
      check("ctrl reset", 16'h0, 16'(rd));
      check("dest reset", 16'h1, 16'(destination_bank_select));
      cpu.sfr_write(isbsc_pkg::ADDR_PROG_CTRL, 8'h13);
      cpu.sfr_read(isbsc_pkg::ADDR_PROG_CTRL, rd);
      check("ctrl locked", 16'h0, 16'(rd));
      cpu.unlock();
      cpu.sfr_write(isbsc_pkg::ADDR_PROG_CTRL, 8'h13);
      cpu.sfr_read(isbsc_pkg::ADDR_PROG_CTRL, rd);
      check("ctrl open", 16'h13, 16'(rd));
      check("aux on", 16'h1, 16'(aux_ram_enable));
      check("dest app", 16'h0, 16'(destination_bank_select));
      cpu.sfr_write(isbsc_pkg::ADDR_UNLOCK, 8'h00);
      cpu.sfr_write(isbsc_pkg::ADDR_PROG_CTRL, 8'h10);
      check("ctrl reclosed", 16'h1, 16'(loader_location_select));
      cpu.unlock();
      cpu.sfr_write(isbsc_pkg::ADDR_PROG_CTRL, 8'h00);
      check("dest loader", 16'h1, 16'(destination_bank_select));
      check("aux off", 16'h0, 16'(aux_ram_enable));
   endtask
   task automatic t_flash();
      cpu.wake();
      check("isp without enable", 16'h0, 16'(isp_mode));
      cpu.sfr_write(isbsc_pkg::ADDR_PROG_CTRL, 8'h03);
      cpu.set_idle(1'b1);
      flash(isbsc_pkg::FLASH_READ, 1'b0);
      cpu.wake();
      check("isp entered", 16'h1, 16'(isp_mode));
      check("exec in isp", 16'h1, 16'(exec_loader_bank));
      cpu.set_idle(1'b0);
      flash(isbsc_pkg::FLASH_ERASE, 1'b0);
      cpu.set_idle(1'b1);
      flash(isbsc_pkg::FLASH_ERASE, 1'b1);
      flash(isbsc_pkg::FLASH_PROGRAM, 1'b1);
      flash(isbsc_pkg::FLASH_READ, 1'b1);
      flash(4'h3, 1'b0);
      prog(1'b1, 1'b0, 1'b0, 1'b1, isbsc_pkg::ADDR_SECURITY, 8'h00);
      check("special in isp", 16'h1, 16'(prog_refused));
      cpu.sfr_write(isbsc_pkg::ADDR_PROG_CTRL, 8'h00);
      flash(isbsc_pkg::FLASH_ERASE, 1'b0);
      flash(isbsc_pkg::FLASH_PROGRAM, 1'b0);
      flash(isbsc_pkg::FLASH_READ, 1'b1);
      cpu.wake();
      cpu.set_idle(1'b0);
   endtask
   task automatic t_security();
      prog(1'b1, 1'b0, 1'b0, 1'b1, isbsc_pkg::ADDR_SECURITY, 8'h00);
      check("security read", 16'hff, 16'(prog_rdata));
      prog(1'b1, 1'b0, 1'b0, 1'b1, isbsc_pkg::ADDR_COMPANY, 8'h00);
      check("company id", 16'h5a, 16'(prog_rdata));
      prog(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h00);
      check("code go", 16'h1, 16'(prog_code_go));
      prog(1'b0, 1'b1, 1'b0, 1'b1, isbsc_pkg::ADDR_DEVICE, 8'h00);
      check("id write", 16'h1, 16'(prog_refused));
      movc(1'b0, 1'b1);
      port0(8'h5a, 8'h5a);
      prog(1'b0, 1'b1, 1'b0, 1'b1, isbsc_pkg::ADDR_SECURITY, 8'hf9);
      prog(1'b0, 1'b1, 1'b0, 1'b1, isbsc_pkg::ADDR_SECURITY, 8'hff);
      check("security sticky", 16'hf9, 16'(sec));
      movc(1'b0, 1'b0);
      movc(1'b1, 1'b1);
      port0(8'h5a, 8'h5a ^ 8'h3c);
      prog(1'b0, 1'b1, 1'b0, 1'b1, isbsc_pkg::ADDR_SECURITY, 8'hfe);
      prog(1'b1, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h00);
      check("locked code", 16'h1, 16'(prog_refused));
      prog(1'b1, 1'b0, 1'b0, 1'b1, isbsc_pkg::ADDR_SECURITY, 8'h00);
      check("locked special", 16'h1, 16'(prog_refused));
      prog(1'b0, 1'b0, 1'b1, 1'b0, 16'h0000, 8'h00);
      check("erase go", 16'h1, 16'(prog_code_go));
      check("erased", 16'hff, 16'(sec));
      port0(8'h5a, 8'h5a);
   endtask
   task automatic t_boot();
      do_reset(1'b0, 1'b0, 1'b1);
      cpu.sfr_read(isbsc_pkg::ADDR_PROG_CTRL, rd);
      check("indicator", 16'h1, 16'(rd[7]));
      check("exec loader", 16'h1, 16'(exec_loader_bank));
      do_reset(1'b1, 1'b0, 1'b1);
      check("one pin low", 16'h0, 16'(loader_boot_mode));
      do_reset(1'b1, 1'b1, 1'b0);
      check("p4 pin low", 16'h1, 16'(loader_boot_mode));
      do_reset(1'b1, 1'b1, 1'b1);
      check("app boot", 16'h0, 16'(loader_boot_mode));
      check("exec app", 16'h0, 16'(exec_loader_bank));
      cpu.unlock();
      cpu.sfr_write(isbsc_pkg::ADDR_PROG_CTRL, 8'h13);
      boot_p4_3 = 1'b0;
      cpu.sfr_write(isbsc_pkg::ADDR_PROG_CTRL, 8'h83);
      check("soft reboot", 16'h1, 16'(soft_reboot));
      repeat (2) @(negedge clk);
      check("reboot clears", 16'h0, 16'({aux_ram_enable, program_enable}));
      check("reboot straps", 16'h1, 16'(loader_boot_mode));
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_b, boot_p2_7, boot_p2_6, boot_p4_3} = 4'h7;
      {flash_req, prog_rd, prog_wr, prog_erase_all, prog_loader_bank} = 5'h0;
      {movc_req, movc_from_internal, movc_target_internal} = 3'h0;
      flash_cmd = 4'h0;
      prog_addr = 16'h0000;
      prog_wdata = 8'h00;
      p0_in = 8'h00;
      do_reset(1'b1, 1'b1, 1'b1);
      t_ctrl();
      t_flash();
      t_security();
      t_boot();
      wrap_up();
   end
endmodule
